/* sosr_defs.vh */
// Bit positions, codes and timing constants of the safety status words
`ifndef SOSR_DEFS_VH
`define SOSR_DEFS_VH

// First status word
`define SOSR_B_NORMAL        0
`define SOSR_B_SELFTEST      1
`define SOSR_B_TORQUE_OFF    2
`define SOSR_B_STOP_A        3
`define SOSR_B_STOP_B        4
`define SOSR_B_SPEED_A       5
`define SOSR_B_SPEED_B       6
`define SOSR_B_RSV_LO        7
`define SOSR_B_RSV_HI        10
`define SOSR_B_INT_FAIL      11
`define SOSR_B_RST_REQ       12
`define SOSR_B_FS_PEND       13
`define SOSR_B_EXT_FAIL      14
`define SOSR_B_SF_PEND       15
`define SOSR_B_GEN_RESET     16
`define SOSR_B_CUST_CONF     17
`define SOSR_B_CUST_ABORT    18
`define SOSR_B_CUST_REQ      19
`define SOSR_B_SPD_SUSP      20
`define SOSR_B_SELFTEST_WARN 21
`define SOSR_B_IN1_WARN      22
`define SOSR_B_IN2_WARN      23
`define SOSR_B_ERR_LO        24
`define SOSR_B_ERR_HI        31

// Second status word
`define SOSR_B2_IN1_LO       0
`define SOSR_B2_IN1_HI       1
`define SOSR_B2_IN2_LO       2
`define SOSR_B2_IN2_HI       3
`define SOSR_B2_BLANK        4

// Input state codes
`define SOSR_IN_INACTIVE     2'h0
`define SOSR_IN_ACTIVE       2'h1
`define SOSR_IN_PENDING      2'h3

// LED colour codes: {red, green}, yellow is both
`define SOSR_LED_OFF         2'h0
`define SOSR_LED_GREEN       2'h1
`define SOSR_LED_RED         2'h2
`define SOSR_LED_YELLOW      2'h3

// Flash half period in ns and in cycles of the 100 MHz clock
`define SOSR_FLASH_HALF_NS   250000000
`define SOSR_CLK_PERIOD_NS   10
`define SOSR_FLASH_HALF_CYC  (`SOSR_FLASH_HALF_NS / `SOSR_CLK_PERIOD_NS)

`define SOSR_ZERO32          32'h0000_0000
`endif

/* sosr_led_flash.v */
// Flash pattern generator that paces the status LED
`include "sosr_defs.vh"
module sosr_led_flash #(
   parameter integer HALF_CYC = `SOSR_FLASH_HALF_CYC
) (
   // Clock and reset
   input  wire clk_sys,
   input  wire sys_rst,
   // Pattern
   output reg  flash_q
);
   reg [31:0] cnt_q;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q   <= 32'h0000_0000;
         flash_q <= 1'b0;
      end else if (cnt_q >= HALF_CYC - 1) begin
         cnt_q   <= 32'h0000_0000;
         flash_q <= ~flash_q;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end
endmodule

/* sosr_status.v */
// Safety option status words, fault classification and LED encoding
// Behaviour
// - Bit 0 high in normal operation, low when function, reaction or warning active
// - Bit 1 set while power-up self test runs
// - Bits 2,3,4 follow torque removal, stop a, stop b activity
// - Bits 5,6 high while limited speed a or b active
// - Function flags show active functions only, not configured ones
// - Bits 7 to 10 reserved
// - Bit 11 shows active internal failure
// - Bit 12 shows reset of option required
// - Bit 13 shows pending fail-safe state
// - Bit 14 shows active external failure
// - Bit 15 shows pending safety function
// - Bits 16 to 19 are reset-done and customisation events
// - Bits 20 to 23 are speed suspension, self test and offline warnings
// - Bits 24 to 31 hold the current error code
// - Second word bits 1:0 give input one state: 00, 01, 11 pending
// - Second word bits 3:2 give input two state, same coding
// - Second word bit 4 high in blank initial state
// - Second word bits 5 to 31 reserved
// - Fatal error stops processing, output off, cleared only by power, restart or reconfiguration
// - Alarm turns output off, keeps running, reset by input two, panel, bus, restart
// - LED: green flash, green steady, yellow flash, red flash, red steady
// - External failures clear on reset, internal only on restart or reconfiguration
// - First word readable by any interface and as cyclic data
`include "sosr_defs.vh"
module sosr_status #(
   parameter integer FLASH_HALF_CYC = `SOSR_FLASH_HALF_CYC
) (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        sys_rst,
   // Safety function activity from the monitoring logic
   input  wire        power_up_self_test,
   input  wire        safe_torque_removal,
   input  wire        controlled_stop_variant_a,
   input  wire        controlled_stop_variant_b,
   input  wire        limited_speed_variant_a,
   input  wire        limited_speed_variant_b,
   input  wire        safety_function_pending,
   input  wire        fail_safe_pending,
   input  wire        reset_required,
   // Fault reports, pulses with their error code
   input  wire        internal_fail_set,
   input  wire        external_fail_set,
   input  wire [7:0]  fail_code,
   // Clearing sources
   input  wire        safety_input_two_channel_a_reset,
   input  wire        local_operator_panel_reset,
   input  wire        fieldbus_reset,
   input  wire        restart_cmd,
   input  wire        reconfigure_done,
   // Event and warning pulses
   input  wire        general_reset_done,
   input  wire        cust_confirmed,
   input  wire        cust_aborted,
   input  wire        cust_requested,
   input  wire        speed_monitor_suspended,
   input  wire        self_test_warning,
   input  wire        input_one_offline_test_warning,
   input  wire        input_two_offline_test_warning,
   input  wire        event_ack,
   // Digital input states and configuration
   input  wire        safety_input_one_active,
   input  wire        safety_input_one_pending,
   input  wire        safety_input_two_active,
   input  wire        safety_input_two_pending,
   input  wire        blank_initial_state,
   input  wire        config_validated,
   // Status words, read-only
   output reg  [31:0] safety_status_word,
   output reg  [31:0] safety_input_status_word,
   // Outputs to the drive
   output wire        safety_output,
   output wire        cyclic_run,
   output wire        fatal_error,
   output wire        alarm,
   output wire        led_green,
   output wire        led_red
);
   localparam [2:0] ST_RUN   = 3'h1;
   localparam [2:0] ST_ALARM = 3'h2;
   localparam [2:0] ST_FATAL = 3'h4;

   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg  [7:0] err_code_q;
   reg  [7:0] events_q;
   reg  [7:0] events_d;
   reg  [4:0] func_hold_q;
   wire       flash;
   wire       ext_reset;
   wire       int_reset;
   wire [4:0] func_now;
   wire [7:0] event_in;
   wire       any_func;
   wire       any_warn;
   reg  [1:0] led_colour;
   reg        led_blink;
   // Next values of the two status words
   reg [31:0] status_d;
   reg [31:0] input_d;
   // Normal operation summary for bit 0
   wire       normal_op;

   // Encodes an input state: pending takes precedence over active
   function [1:0] in_code;
      input act;
      input pend;
      begin
         if (pend)
            in_code = `SOSR_IN_PENDING;
         else if (act)
            in_code = `SOSR_IN_ACTIVE;
         else
            in_code = `SOSR_IN_INACTIVE;
      end
   endfunction

   sosr_led_flash #(
      .HALF_CYC (FLASH_HALF_CYC)
   ) u_flash (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .flash_q  (flash)
   );

   // Any configured external source clears an alarm
   assign ext_reset = safety_input_two_channel_a_reset |
                      local_operator_panel_reset |
                      fieldbus_reset |
                      restart_cmd;
   // Internal failures need a restart or a fresh configuration
   assign int_reset = restart_cmd |
                      reconfigure_done;

   // Fault classification: in the same cycle an internal fault beats any clear, an external fault only an alarm clear
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (internal_fail_set)
               state_d = ST_FATAL;
            else if (external_fail_set)
               state_d = ST_ALARM;
         end
         ST_ALARM: begin
            if (internal_fail_set)
               state_d = ST_FATAL;
            else if (!external_fail_set && ext_reset)
               state_d = ST_RUN;
         end
         ST_FATAL: begin
            if (!internal_fail_set && int_reset)
               state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   assign fatal_error   = state_q == ST_FATAL;
   assign alarm         = state_q == ST_ALARM;
   assign safety_output = state_q == ST_RUN;
   assign cyclic_run    = !fatal_error;

   assign func_now = {limited_speed_variant_b, limited_speed_variant_a,
                      controlled_stop_variant_b, controlled_stop_variant_a,
                      safe_torque_removal};
   assign event_in = {input_two_offline_test_warning, input_one_offline_test_warning,
                      self_test_warning, speed_monitor_suspended, cust_requested,
                      cust_aborted, cust_confirmed, general_reset_done};

   // Event bits are sticky until acknowledged; a new event wins over the ack
   always @* begin
      if (event_ack)
         events_d = 8'h00;
      else
         events_d = events_q;
      events_d = events_d | event_in;
   end

   assign any_func = |func_hold_q | power_up_self_test;
   // Warning events sit in the upper half of the event field
   assign any_warn = |events_q[`SOSR_B_IN2_WARN - `SOSR_B_GEN_RESET:
                              `SOSR_B_SPD_SUSP - `SOSR_B_GEN_RESET];

   // Any active or pending function, reaction or warning ends normal operation
   assign normal_op = !(any_func | fail_safe_pending | safety_function_pending |
                        any_warn | !safety_output);

   // Fault classification state
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Sticky event and warning bits
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         events_q <= 8'h00;
      end else begin
         events_q <= events_d;
      end
   end

   // A fatal error freezes the last active function for display
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         func_hold_q <= 5'h00;
      end else if (!fatal_error) begin
         func_hold_q <= func_now;
      end
   end

   // Error code of the reported fault, dropped once the option runs again
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         err_code_q <= 8'h00;
      end else if (internal_fail_set | external_fail_set) begin
         err_code_q <= fail_code;
      end else if (state_d == ST_RUN) begin
         err_code_q <= 8'h00;
      end
   end

   // Next value of the first word; reserved positions stay zero
   always @* begin
      status_d = `SOSR_ZERO32;
      status_d[`SOSR_B_NORMAL]        = normal_op;
      status_d[`SOSR_B_SELFTEST]      = power_up_self_test;
      status_d[`SOSR_B_TORQUE_OFF]    = func_hold_q[0];
      status_d[`SOSR_B_STOP_A]        = func_hold_q[1];
      status_d[`SOSR_B_STOP_B]        = func_hold_q[2];
      status_d[`SOSR_B_SPEED_A]       = func_hold_q[3];
      status_d[`SOSR_B_SPEED_B]       = func_hold_q[4];
      status_d[`SOSR_B_INT_FAIL]      = fatal_error;
      status_d[`SOSR_B_RST_REQ]       = reset_required | alarm;
      status_d[`SOSR_B_FS_PEND]       = fail_safe_pending;
      status_d[`SOSR_B_EXT_FAIL]      = alarm;
      status_d[`SOSR_B_SF_PEND]       = safety_function_pending;
      status_d[`SOSR_B_IN2_WARN:`SOSR_B_GEN_RESET] = events_q;
      status_d[`SOSR_B_ERR_HI:`SOSR_B_ERR_LO]      = err_code_q;
   end

   // Next value of the second word
   always @* begin
      input_d = `SOSR_ZERO32;
      input_d[`SOSR_B2_IN1_HI:`SOSR_B2_IN1_LO] =
         in_code(safety_input_one_active, safety_input_one_pending);
      input_d[`SOSR_B2_IN2_HI:`SOSR_B2_IN2_LO] =
         in_code(safety_input_two_active, safety_input_two_pending);
      input_d[`SOSR_B2_BLANK] = blank_initial_state;
   end

   // Both words are registered so every interface reads the same settled value
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         safety_status_word       <= `SOSR_ZERO32;
         safety_input_status_word <= `SOSR_ZERO32;
      end else begin
         safety_status_word       <= status_d;
         safety_input_status_word <= input_d;
      end
   end

   // LED selection, worst condition first
   always @* begin
      if (fatal_error) begin
         led_colour = `SOSR_LED_RED;
         led_blink  = 1'b0;
      end else if (alarm) begin
         led_colour = `SOSR_LED_RED;
         led_blink  = 1'b1;
      end else if (!config_validated) begin
         led_colour = `SOSR_LED_YELLOW;
         led_blink  = 1'b1;
      end else if (safety_input_one_active | safety_input_two_active | any_func) begin
         led_colour = `SOSR_LED_GREEN;
         led_blink  = 1'b0;
      end else begin
         led_colour = `SOSR_LED_GREEN;
         led_blink  = 1'b1;
      end
   end

   // Gates one colour with the flash pattern when that colour blinks
   // Both colours share one pattern, so yellow flashes as a single colour
   function led_drive;
      input colour_on;
      input blink;
      input pattern;
      begin
         led_drive = colour_on & (!blink | pattern);
      end
   endfunction

   assign led_green = led_drive(led_colour[0], led_blink, flash);
   assign led_red   = led_drive(led_colour[1], led_blink, flash);
endmodule

/* sosr_checker.sv */
// Concurrent checks on the ports of the status block
module sosr_checker (
   // Clock and reset
   input wire        clk_sys,
   input wire        sys_rst,
   // Fault and clearing inputs
   input wire        internal_fail_set,
   input wire        external_fail_set,
   input wire        restart_cmd,
   input wire        reconfigure_done,
   input wire        safety_input_two_channel_a_reset,
   input wire        local_operator_panel_reset,
   input wire        fieldbus_reset,
   input wire [7:0]  fail_code,
   // Observed outputs
   input wire [31:0] safety_status_word,
   input wire [31:0] safety_input_status_word,
   input wire        safety_output,
   input wire        cyclic_run,
   input wire        fatal_error,
   input wire        alarm,
   input wire        led_green,
   input wire        led_red
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Any source that may legally clear an alarm
   wire ext_clr = safety_input_two_channel_a_reset | local_operator_panel_reset |
                  fieldbus_reset | restart_cmd;
   property p_rsv; safety_input_status_word[31:5] == 27'h0 && safety_status_word[10:7] == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_fatal; internal_fail_set |=> fatal_error && !safety_output && !cyclic_run;
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal reaction missing");
   property p_fhold; fatal_error && !restart_cmd && !reconfigure_done |=> fatal_error;
   endproperty
   a_fhold: assert property (p_fhold) else $error("fatal cleared early");
   property p_code; internal_fail_set && !fatal_error |-> ##2
      safety_status_word[31:24] == $past(fail_code, 2) && safety_status_word[11];
   endproperty
   a_code: assert property (p_code) else $error("error code wrong");
   property p_alarm; external_fail_set && !internal_fail_set && !fatal_error
      |=> alarm && !safety_output && cyclic_run;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm reaction missing");
   property p_ahold; alarm && reconfigure_done && !ext_clr && !external_fail_set &&
      !internal_fail_set |=> alarm;
   endproperty
   a_ahold: assert property (p_ahold) else $error("alarm cleared by internal source");
   property p_ledf; fatal_error |-> led_red && !led_green; endproperty
   a_ledf: assert property (p_ledf) else $error("fatal LED wrong");
   property p_bit0; $past(fatal_error) |-> !safety_status_word[0]; endproperty
   a_bit0: assert property (p_bit0) else $error("normal bit during fault");
   c_fatal: cover property (fatal_error);
   c_alarm: cover property (alarm);
   c_event: cover property (safety_status_word[16]);
endmodule
bind sosr_status sosr_checker u_chk (.clk_sys, .sys_rst, .internal_fail_set,
   .safety_input_two_channel_a_reset, .local_operator_panel_reset, .fieldbus_reset,
   .external_fail_set, .restart_cmd, .reconfigure_done, .fail_code, .safety_status_word,
   .safety_input_status_word, .safety_output, .cyclic_run, .fatal_error, .alarm,
   .led_green, .led_red);

/* sosr_host_model.sv */
// Host reader that samples both status words every cycle
module sosr_host_model (
   // Clock
   input wire          clk_sys,
   // Words from the option
   input wire [31:0]   safety_status_word,
   input wire [31:0]   safety_input_status_word,
   // Last values read
   output logic [31:0] rd_w1_q,
   output logic [31:0] rd_w2_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // Read only: the host never writes the words back
   always @(posedge clk_sys) begin
      rd_w1_q <= safety_status_word;
      rd_w2_q <= safety_input_status_word;
   end
endmodule

/* sosr_tb.sv */
// Self-checking bench for the safety status words
`include "sosr_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [13:0] i; logic [15:0] w; logic [4:0] v; logic c;} sosr_row_t;
   logic        clk_sys, sys_rst, ifs, efs, ack, cv;
   logic [13:0] fn;
   logic [7:0]  ev, code;
   logic [4:0]  clr;
   logic [31:0] m1;
   wire  [31:0] w1, w2, hw1, hw2;
   wire         so, cr, fe, al, lg, lr;
   integer      miscompares, cmp_count, k;
   // Level inputs, expected first word, second word, bit 0 checked
   sosr_row_t   rows [14] = '{
      '{14'h0000, 16'h0001, 5'h00, 1'h1}, '{14'h0001, 16'h0002, 5'h00, 1'h0},
      '{14'h0002, 16'h0004, 5'h00, 1'h1}, '{14'h0004, 16'h0008, 5'h00, 1'h1},
      '{14'h0008, 16'h0010, 5'h00, 1'h1}, '{14'h0010, 16'h0020, 5'h00, 1'h1},
      '{14'h0020, 16'h0040, 5'h00, 1'h1}, '{14'h0040, 16'h8000, 5'h00, 1'h1},
      '{14'h0080, 16'h2000, 5'h00, 1'h1}, '{14'h0100, 16'h1000, 5'h00, 1'h0},
      '{14'h0200, 16'h0000, 5'h01, 1'h0}, '{14'h0600, 16'h0000, 5'h03, 1'h0},
      '{14'h0800, 16'h0000, 5'h04, 1'h0}, '{14'h3000, 16'h0000, 5'h1C, 1'h0}};
   sosr_status #(.FLASH_HALF_CYC(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .power_up_self_test(fn[0]), .safe_torque_removal(fn[1]),
      .controlled_stop_variant_a(fn[2]), .controlled_stop_variant_b(fn[3]),
      .limited_speed_variant_a(fn[4]), .limited_speed_variant_b(fn[5]),
      .safety_function_pending(fn[6]), .fail_safe_pending(fn[7]), .reset_required(fn[8]),
      .internal_fail_set(ifs), .external_fail_set(efs), .fail_code(code),
      .safety_input_two_channel_a_reset(clr[0]), .local_operator_panel_reset(clr[1]),
      .fieldbus_reset(clr[2]), .restart_cmd(clr[3]), .reconfigure_done(clr[4]),
      .general_reset_done(ev[0]), .cust_confirmed(ev[1]), .cust_aborted(ev[2]),
      .cust_requested(ev[3]), .speed_monitor_suspended(ev[4]), .self_test_warning(ev[5]),
      .input_one_offline_test_warning(ev[6]), .input_two_offline_test_warning(ev[7]),
      .event_ack(ack), .safety_input_one_active(fn[9]), .safety_input_one_pending(fn[10]),
      .safety_input_two_active(fn[11]), .safety_input_two_pending(fn[12]),
      .blank_initial_state(fn[13]), .config_validated(cv), .safety_status_word(w1),
      .safety_input_status_word(w2), .safety_output(so), .cyclic_run(cr),
      .fatal_error(fe), .alarm(al), .led_green(lg), .led_red(lr));
   sosr_host_model u_host (.clk_sys(clk_sys), .safety_status_word(w1),
      .safety_input_status_word(w2), .rd_w1_q(hw1), .rd_w2_q(hw2));
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   function automatic logic [1:0] cls(input int n);
      return n == 0 ? 2'h0 : n == 16 ? 2'h1 : 2'h2;
   endfunction
   // LED class per colour: 0 dark, 1 steady, 2 flashing
   task automatic led(input logic [1:0] er, input logic [1:0] eg);
      int r, g;
      r = 0;
      g = 0;
      repeat (16) begin
         tick(1);
         r += (lr === 1'b1);
         g += (lg === 1'b1);
      end
      chk("led", {cls(r), cls(g)}, {er, eg});
   endtask
   task automatic fault(input logic i, input logic [7:0] c);
      @(posedge clk_sys) {ifs, efs, code} <= {i, !i, c};
      @(posedge clk_sys) {ifs, efs} <= 2'h0;
      tick(4);
   endtask
   task automatic clear(input int b);
      @(posedge clk_sys) clr <= 5'h01 << b;
      @(posedge clk_sys) clr <= 5'h00;
      tick(4);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      report_and_stop;
   end
   initial begin
      {miscompares, cmp_count, sys_rst, fn, ev, ifs, efs, code, clr, ack, cv} = 1;
      cv = 1;
      sys_rst = 1;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 0;
      for (k = 0; k < 14; k++) begin
         @(posedge clk_sys) fn <= rows[k].i;
         tick(4);
         m1 = {31'h7FFFFFFF, rows[k].c};
         chk("w1", hw1 & m1, {16'h0, rows[k].w} & m1);
         chk("w2", hw2, {27'h0, rows[k].v});
      end
      @(posedge clk_sys) fn <= 14'h0;
      for (k = 0; k < 8; k++) begin
         @(posedge clk_sys) ev <= 8'h01 << k;
         @(posedge clk_sys) ev <= 8'h00;
         tick(4);
         chk("event", hw1[23:16], 8'h01 << k);
         @(posedge clk_sys) ack <= 1;
         @(posedge clk_sys) ack <= 0;
         tick(4);
         chk("event_ack", hw1[23:16], 8'h00);
      end
      // Event and acknowledge together: the event must not be lost
      @(posedge clk_sys) {ev, ack} <= 9'h003;
      @(posedge clk_sys) {ev, ack} <= 9'h000;
      tick(4);
      chk("event_win", hw1[16], 1'b1);
      fault(1, 8'hA5);
      chk("fatal", {fe, so, cr, al}, 4'h8);
      chk("fatal_word", {hw1[31:24], hw1[11], hw1[0]}, 10'h296);
      led(2'h1, 2'h0);
      clear(2);
      chk("fatal_hold", fe, 1'b1);
      clear(3);
      chk("restart", {fe, so, cr, hw1[11], hw1[31:24]}, 12'h600);
      for (k = 0; k < 4; k++) begin
         fault(0, 8'h3C + 8'(k));
         chk("alarm", {al, fe, so, cr, hw1[14], hw1[12], hw1[31:24]},
             {6'h27, code});
         if (k == 0) begin
            led(2'h2, 2'h0);
            clear(4);
            chk("alarm_hold", al, 1'b1);
         end
         clear(k);
         chk("alarm_clr", {al, so}, 2'h1);
      end
      led(2'h0, 2'h2);
      @(posedge clk_sys) cv <= 0;
      led(2'h2, 2'h2);
      // Input one active on a validated option gives steady green
      @(posedge clk_sys) {cv, fn} <= {1'b1, 14'h0200};
      led(2'h0, 2'h1);
      fault(0, 8'h11);
      @(posedge clk_sys) sys_rst <= 1;
      tick(2);
      chk("reset_out", {al, so}, 2'h1);
      chk("reset_words", w1 | w2, 32'h0);
      // Release in mid-run: the words follow the inputs again
      @(posedge clk_sys) sys_rst <= 0;
      tick(3);
      chk("rst_w1", w1, 32'h1);
      chk("rst_w2", w2, 32'h1);
      report_and_stop;
   end
endmodule
